// *** core/power_unit.sv ***
// Power-mode and wake-up control with its two special-function registers.
// Assumes the core's SFR bus and event pulses are synchronous to CLK_IN.
`timescale 1ns/1ps
module power_unit (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   // SFR bus
   input wire logic [7:0] SFR_ADDR_IN,
   input wire logic SFR_WR_IN,
   input wire logic SFR_RD_IN,
   input wire logic [7:0] SFR_WDATA_IN,
   output logic [7:0] SFR_RDATA_OUT,
   // Wake-up sources
   input wire logic RST_GLITCH_IN,
   input wire logic RTC_OSC_FAIL_IN,
   input wire logic RTC_ALARM_IN,
   input wire logic PORT_MATCH_IN,
   input wire logic CMP_RISE_IN,
   input wire logic IRQ_IN,
   // Oscillator control
   input wire logic LPOSC_OFF_REQ_IN,
   output logic LPOSC_OFF_OUT,
   // Mode status
   output logic [2:0] MODE_OUT,
   output logic WAKE_OUT
);
   // ***********************
   // Reset release
   // ***********************
   logic rst_meta_r;
   logic rst_n;

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ***********************
   // Bus decode
   // ***********************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction : hit

   logic cfg_wr;
   logic ctl_wr;
   assign cfg_wr = SFR_WR_IN && hit(SFR_ADDR_IN,
      power_unit_pkg::WAKE_CFG_ADDR);
   assign ctl_wr = SFR_WR_IN && hit(SFR_ADDR_IN,
      power_unit_pkg::MODE_CTL_ADDR);

   // ***********************
   // Wake flags
   // ***********************
   power_unit_pkg::power_mode_t mode_r;
   power_unit_pkg::power_mode_t mode_nxt;
   logic [3:0] wake_en_r;
   logic [3:0] wake_en_nxt;
   logic [3:0] src_evt;
   logic [3:0] src_en;
   logic [3:0] src_flag;
   logic glitch_flag;
   logic flag_clear;
   logic any_flag;
   logic asleep;

   assign asleep = (mode_r == power_unit_pkg::MODE_SUSPEND) ||
                   (mode_r == power_unit_pkg::MODE_SLEEP);
   assign src_evt = {RTC_OSC_FAIL_IN, RTC_ALARM_IN, PORT_MATCH_IN,
                     CMP_RISE_IN};
   // Comparator flag only records an edge that caused a wake-up
   assign src_en = {wake_en_r[3:1],
                    wake_en_r[0] && asleep};
   assign flag_clear = cfg_wr &&
      SFR_WDATA_IN[power_unit_pkg::CFG_CLEAR_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < power_unit_pkg::SRC_N; gi++) begin : g_src
         wake_flag_cell u_flag (
            .clk(CLK_IN),
            .rst_n(rst_n),
            .event_in(src_evt[gi]),
            .enable_in(src_en[gi]),
            .clear_in(flag_clear),
            .flag_out(src_flag[gi])
         );
      end
   endgenerate

   wake_flag_cell u_glitch (
      .clk(CLK_IN),
      .rst_n(rst_n),
      .event_in(RST_GLITCH_IN),
      .enable_in(1'b1),
      .clear_in(flag_clear),
      .flag_out(glitch_flag)
   );

   assign any_flag = glitch_flag || (|src_flag);

   // ***********************
   // Mode control
   // ***********************
   logic [5:0] gf_r;
   logic [5:0] gf_nxt;
   logic [1:0] settle_r;
   logic [1:0] settle_nxt;
   logic wake_r;
   logic wake_nxt;
   logic lposc_r;
   logic lposc_nxt;
   logic wake_hit;

   assign wake_hit = |(src_evt & wake_en_r);

   always_comb begin
      mode_nxt = mode_r;
      wake_en_nxt = wake_en_r;
      gf_nxt = gf_r;
      settle_nxt = settle_r;
      wake_nxt = 1'b0;
      lposc_nxt = LPOSC_OFF_REQ_IN && !any_flag;
      if (settle_r != power_unit_pkg::SETTLE_DONE) begin
         settle_nxt = settle_r - 2'h1;
      end
      if (cfg_wr) begin
         wake_en_nxt = SFR_WDATA_IN[3:0];
      end
      if (ctl_wr) begin
         gf_nxt = SFR_WDATA_IN[7:2];
      end
      case (mode_r)
         power_unit_pkg::MODE_RUN: begin
            if (cfg_wr && !any_flag &&
                SFR_WDATA_IN[power_unit_pkg::CFG_SLEEP_BIT]) begin
               mode_nxt = power_unit_pkg::MODE_SLEEP;
            end else if (cfg_wr && !any_flag &&
                SFR_WDATA_IN[power_unit_pkg::CFG_SUSPEND_BIT]) begin
               mode_nxt = power_unit_pkg::MODE_SUSPEND;
            end else if (ctl_wr &&
                SFR_WDATA_IN[power_unit_pkg::CTL_STOP_BIT]) begin
               mode_nxt = power_unit_pkg::MODE_STOP;
            end else if (ctl_wr &&
                SFR_WDATA_IN[power_unit_pkg::CTL_IDLE_BIT]) begin
               mode_nxt = power_unit_pkg::MODE_IDLE;
            end
         end
         power_unit_pkg::MODE_IDLE: begin
            if (IRQ_IN || wake_hit) begin
               mode_nxt = power_unit_pkg::MODE_RUN;
               wake_nxt = 1'b1;
            end
         end
         // Only a reset leaves stop mode
         power_unit_pkg::MODE_STOP: begin
            mode_nxt = power_unit_pkg::MODE_STOP;
         end
         power_unit_pkg::MODE_SUSPEND: begin
            if (wake_hit) begin
               mode_nxt = power_unit_pkg::MODE_RUN;
               wake_nxt = 1'b1;
               settle_nxt = power_unit_pkg::SETTLE_CYC;
            end
         end
         power_unit_pkg::MODE_SLEEP: begin
            if (wake_hit) begin
               mode_nxt = power_unit_pkg::MODE_RUN;
               wake_nxt = 1'b1;
            end
         end
         default: begin
            mode_nxt = power_unit_pkg::MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= power_unit_pkg::MODE_RUN;
         wake_en_r <= power_unit_pkg::WAKE_EN_RST;
         gf_r <= power_unit_pkg::GF_RST;
         settle_r <= power_unit_pkg::SETTLE_DONE;
         wake_r <= 1'b0;
         lposc_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         wake_en_r <= wake_en_nxt;
         gf_r <= gf_nxt;
         settle_r <= settle_nxt;
         wake_r <= wake_nxt;
         lposc_r <= lposc_nxt;
      end
   end

   // ***********************
   // Read path
   // ***********************
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic flag_mask;

   assign flag_mask = (settle_r != power_unit_pkg::SETTLE_DONE);

   // Mode-select and clear bits have no read value
   always_comb begin
      rdata_nxt = rdata_r;
      if (SFR_RD_IN) begin
         rdata_nxt = power_unit_pkg::RDATA_RST;
         if (hit(SFR_ADDR_IN, power_unit_pkg::WAKE_CFG_ADDR) &&
             !flag_mask) begin
            rdata_nxt[power_unit_pkg::CFG_GLITCH_BIT] = glitch_flag;
            rdata_nxt[3:0] = src_flag;
         end else if (hit(SFR_ADDR_IN, power_unit_pkg::MODE_CTL_ADDR)) begin
            rdata_nxt[7:2] = gf_r;
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= power_unit_pkg::RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign SFR_RDATA_OUT = rdata_r;
   assign MODE_OUT = mode_r;
   assign WAKE_OUT = wake_r;
   assign LPOSC_OFF_OUT = lposc_r;

   // ***********************
   // Assertions
   // ***********************
   sequence s_run_cfg_ok;
      mode_r == power_unit_pkg::MODE_RUN && cfg_wr && !any_flag;
   endsequence

   sequence s_susp_wake;
      mode_r == power_unit_pkg::MODE_SUSPEND && wake_hit;
   endsequence

   property p_sleep_enter;
      @(posedge CLK_IN) disable iff (!rst_n)
      s_run_cfg_ok ##0 SFR_WDATA_IN[7] |=>
         mode_r == power_unit_pkg::MODE_SLEEP;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter)
      else $error("sleep write did not enter sleep");

   property p_suspend_enter;
      @(posedge CLK_IN) disable iff (!rst_n)
      s_run_cfg_ok ##0 (SFR_WDATA_IN[7:6] == 2'h1) |=>
         mode_r == power_unit_pkg::MODE_SUSPEND;
   endproperty
   a_suspend_enter: assert property (p_suspend_enter)
      else $error("suspend write did not enter suspend");

   property p_clear;
      @(posedge CLK_IN) disable iff (!rst_n)
      flag_clear && !RST_GLITCH_IN && !(|src_evt) |=>
         !any_flag;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear left a wake flag set");

   property p_glitch;
      @(posedge CLK_IN) disable iff (!rst_n)
      RST_GLITCH_IN |=> glitch_flag;
   endproperty
   a_glitch: assert property (p_glitch)
      else $error("reset glitch not flagged");

   property p_refuse;
      @(posedge CLK_IN) disable iff (!rst_n)
      mode_r == power_unit_pkg::MODE_RUN && any_flag && cfg_wr &&
      !ctl_wr |=> mode_r == power_unit_pkg::MODE_RUN && !LPOSC_OFF_OUT;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("low power entry despite wake flag");

   property p_settle;
      @(posedge CLK_IN) disable iff (!rst_n)
      s_susp_wake |=> flag_mask [*2] ##1 !flag_mask;
   endproperty
   a_settle: assert property (p_settle)
      else $error("flag read mask not two clocks");

   property p_gflags;
      @(posedge CLK_IN) disable iff (!rst_n)
      ctl_wr |=> gf_r == $past(SFR_WDATA_IN[7:2]);
   endproperty
   a_gflags: assert property (p_gflags)
      else $error("general flags not stored");

   property p_wake;
      @(posedge CLK_IN) disable iff (!rst_n)
      asleep && wake_hit |=> mode_r == power_unit_pkg::MODE_RUN &&
         WAKE_OUT ##1 !WAKE_OUT;
   endproperty
   a_wake: assert property (p_wake)
      else $error("enabled event did not wake");

   property p_flag_read;
      @(posedge CLK_IN) disable iff (!rst_n)
      SFR_RD_IN && hit(SFR_ADDR_IN, power_unit_pkg::WAKE_CFG_ADDR) &&
      !flag_mask |=> SFR_RDATA_OUT[3:0] == $past(src_flag);
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("wake flag readback wrong");

endmodule : power_unit

// *** core/power_unit_pkg.sv ***
// Constants shared by the power-mode and wake-up control block.
// Assumes an 8-bit special-function register bus owned by the core.
package power_unit_pkg;

   // ***********************
   // Register addresses
   // ***********************
   localparam logic [7:0] WAKE_CFG_ADDR = 8'hB5;
   localparam logic [7:0] MODE_CTL_ADDR = 8'h87;

   // ***********************
   // Field positions
   // ***********************
   localparam int CFG_SLEEP_BIT = 7;
   localparam int CFG_SUSPEND_BIT = 6;
   localparam int CFG_CLEAR_BIT = 5;
   localparam int CFG_GLITCH_BIT = 4;
   localparam int CTL_STOP_BIT = 1;
   localparam int CTL_IDLE_BIT = 0;
   localparam int GF_LSB = 2;
   localparam int GF_W = 6;
   localparam int SRC_N = 4;

   // ***********************
   // Reset values and timing
   // ***********************
   localparam logic [5:0] GF_RST = 6'h00;
   localparam logic [3:0] WAKE_EN_RST = 4'h0;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [1:0] SETTLE_CYC = 2'h2;
   localparam logic [1:0] SETTLE_DONE = 2'h0;

   // ***********************
   // Power modes
   // ***********************
   typedef enum logic [2:0] {
      MODE_RUN = 3'b000,
      MODE_IDLE = 3'b001,
      MODE_STOP = 3'b010,
      MODE_SUSPEND = 3'b011,
      MODE_SLEEP = 3'b100
   } power_mode_t;

endpackage : power_unit_pkg

// *** core/wake_flag_cell.sv ***
// One sticky wake-up flag.
// Assumes event pulses synchronous to the system clock.
`timescale 1ns/1ps
module wake_flag_cell (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic event_in,
   input wire logic enable_in,
   input wire logic clear_in,
   output logic flag_out
);
   logic flag_r;
   logic flag_nxt;

   // Set wins over a clear in the same cycle
   always_comb begin
      flag_nxt = flag_r;
      if (clear_in) begin
         flag_nxt = 1'b0;
      end
      if (event_in && enable_in) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_out = flag_r;

endmodule : wake_flag_cell

// *** tb/tb.sv ***
// Self-checking bench for the power-mode and wake-up control block.
// Assumes the event model drives all wake sources and the interrupt.
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] CFG = power_unit_pkg::WAKE_CFG_ADDR;
   localparam logic [7:0] CTL = power_unit_pkg::MODE_CTL_ADDR;
   logic clk = 1'b0;
   logic arst_n;
   logic [7:0] addr;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic lposc_req;
   logic [7:0] rdata;
   logic lposc_off;
   logic [2:0] mode;
   logic wake;
   logic [5:0] ev;
   int n_errors = 0;
   int check_count = 0;
   int wake_cnt = 0;

   always #50 clk = ~clk;
   always @(posedge clk) if (wake === 1'b1) wake_cnt++;

   wake_source_model u_src (.clk_in(clk), .ev_out(ev));
   power_unit u_dut (
      .CLK_IN(clk), .ARST_N_IN(arst_n), .SFR_ADDR_IN(addr),
      .SFR_WR_IN(wr), .SFR_RD_IN(rd), .SFR_WDATA_IN(wdata),
      .SFR_RDATA_OUT(rdata), .RST_GLITCH_IN(ev[4]),
      .RTC_OSC_FAIL_IN(ev[3]), .RTC_ALARM_IN(ev[2]),
      .PORT_MATCH_IN(ev[1]), .CMP_RISE_IN(ev[0]), .IRQ_IN(ev[5]),
      .LPOSC_OFF_REQ_IN(lposc_req), .LPOSC_OFF_OUT(lposc_off),
      .MODE_OUT(mode), .WAKE_OUT(wake)
   );

   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // Whole-value writes only, never read-modify-write
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      chk(rdata, exp);
   endtask : rd_reg

   // Bus and oscillator request stay quiet while reset is applied
   task automatic do_reset;
      arst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      lposc_req = 1'b0;
      tick(3);
      arst_n = 1'b1;
      tick(6);
   endtask : do_reset

   task automatic test_done;
      if (n_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   initial begin
      #2000000;
      n_errors++;
      test_done();
   end

   // ****************
   // Sequence
   // ****************
   initial begin
      do_reset();
      chk({5'h00, mode}, 8'h00);
      rd_reg(CTL, 8'h00);
      rd_reg(8'h86, 8'h00);
      wr_reg(CTL, 8'hA8);
      rd_reg(CTL, 8'hA8);
      wr_reg(CTL, 8'h55);
      chk({5'h00, mode}, 8'h01);
      rd_reg(CTL, 8'h54);
      u_src.fire(5);
      tick(1);
      chk({5'h00, mode}, 8'h00);
      chk(8'(wake_cnt), 8'h01);
      for (int i = 1; i < 4; i++) begin
         wr_reg(CFG, 8'h0E);
         u_src.fire(i);
         tick(1);
         rd_reg(CFG, 8'(1 << i));
         wr_reg(CFG, 8'h2E);
         rd_reg(CFG, 8'h00);
      end
      wr_reg(CFG, 8'h0F);
      u_src.fire(0);
      tick(1);
      rd_reg(CFG, 8'h00);
      wr_reg(CFG, 8'h00);
      u_src.fire(1);
      tick(1);
      rd_reg(CFG, 8'h00);
      u_src.fire(4);
      tick(1);
      rd_reg(CFG, 8'h10);
      lposc_req = 1'b1;
      wr_reg(CFG, 8'h8E);
      chk({5'h00, mode}, 8'h00);
      chk({7'h00, lposc_off}, 8'h00);
      wr_reg(CFG, 8'h20);
      tick(1);
      chk({7'h00, lposc_off}, 8'h01);
      lposc_req = 1'b0;
      wr_reg(CFG, 8'h4F);
      chk({5'h00, mode}, 8'h03);
      u_src.fire(0);
      chk({5'h00, mode}, 8'h00);
      rd_reg(CFG, 8'h00);
      tick(1);
      rd_reg(CFG, 8'h01);
      chk(8'(wake_cnt), 8'h02);
      wr_reg(CFG, 8'h20);
      wr_reg(CFG, 8'h82);
      chk({5'h00, mode}, 8'h04);
      u_src.fire(2);
      tick(1);
      chk({5'h00, mode}, 8'h04);
      u_src.fire(1);
      chk({5'h00, mode}, 8'h00);
      tick(2);
      rd_reg(CFG, 8'h02);
      wr_reg(CFG, 8'h20);
      wr_reg(CTL, 8'h02);
      chk({5'h00, mode}, 8'h02);
      u_src.fire(5);
      tick(1);
      chk({5'h00, mode}, 8'h02);
      do_reset();
      chk({5'h00, mode}, 8'h00);
      rd_reg(CTL, 8'h00);
      test_done();
   end
endmodule : tb

// *** tb/wake_source_model.sv ***
// Far-side model: wake-up event sources and the core's interrupt line.
// Assumes fire() is called just after a rising clock edge.
`timescale 1ns/1ps
module wake_source_model (
   // Clock
   input wire logic clk_in,
   // Events: 0 cmp, 1 port, 2 alarm, 3 osc fail, 4 glitch, 5 irq
   output logic [5:0] ev_out
);
   initial ev_out = 6'h00;

   // One-cycle event pulse, taken at the next rising edge
   task automatic fire(input int idx);
      ev_out[idx] = 1'b1;
      @(posedge clk_in);
      #1 ev_out[idx] = 1'b0;
   endtask : fire
endmodule : wake_source_model
